//--- design/reset_pkg.sv
// Purpose: constants and types of the reset status and sequencing block
// Assumes: 10 MHz system clock, word-indexed register port
// Notes:   widths fixed; times in ns, cycle counts derived below
package reset_pkg;

    localparam logic [3:0]  ADDR_RESET_CAUSE   = 4'h0;
    localparam logic [3:0]  ADDR_BATTERY       = 4'h1;

    localparam int          B_TRAP             = 15;
    localparam int          B_ILLEGAL          = 14;
    localparam int          B_DEEP_SLEEP       = 10;
    localparam int          B_MISMATCH         = 9;
    localparam int          B_PIN_RESET        = 7;
    localparam int          B_SOFT_RESET       = 6;
    localparam int          B_SOFT_WDT_EN      = 5;
    localparam int          B_WDT_TIMEOUT      = 4;
    localparam int          B_SLEEP            = 3;
    localparam int          B_IDLE             = 2;
    localparam int          B_BROWNOUT         = 1;
    localparam int          B_POWERON          = 0;

    localparam logic [15:0] RESET_CAUSE_MASK   = 16'hD7FF;
    localparam logic [15:0] RESET_CAUSE_POR    = 16'h0003;
    localparam logic [3:0]  BATTERY_POR        = 4'hE;

    localparam int          PIN_MCLR           = 0;
    localparam int          PIN_VBAT           = 1;
    localparam int          PIN_OSC            = 2;
    localparam logic [2:0]  PIN_INIT           = 3'h1;
    localparam logic [2:0]  PEXIT_INIT         = 3'h5;

    localparam int          CLK_PERIOD_NS      = 100;
    localparam int          T_POR_NS           = 10000;
    localparam int          T_RST_NS           = 2000;
    localparam int          T_VREG_NS          = 10000;
    localparam int          T_CLOCK_FAIL_MONITOR_NS          = 2000;
    localparam logic [8:0]  POR_CYC  = 9'((T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0]  RST_CYC  = 9'((T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0]  VREG_CYC = 9'((T_VREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0]  CLOCK_FAIL_MONITOR_CYC = 9'((T_CLOCK_FAIL_MONITOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0]  OST_LAST           = 10'h3FF;

    localparam logic [1:0]  RT_OTHER           = 2'h0;
    localparam logic [1:0]  RT_BOR             = 2'h1;
    localparam logic [1:0]  RT_POR             = 2'h2;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'b001,
        ST_DELAY = 3'b010,
        ST_RUN   = 3'b100
    } mrst_state_t;

endpackage

//--- design/reset_source_status_and_timing.sv
// Purpose: reset status flags, master reset timing, clock source at reset
// Assumes: event inputs are same-clock pulses; mclr, vbat, osc are pins
// Notes:   status flags live outside the master reset
`timescale 1ns/1ps
module reset_source_status_and_timing
    import reset_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic        por_req_in,
    input  wire logic        bor_detect_in,
    input  wire logic        brownout_fuse_in,
    input  wire logic        mclr_n_in,
    input  wire logic        wdt_timeout_in,
    input  wire logic        reset_instr_in,
    input  wire logic        trap_conflict_in,
    input  wire logic        illegal_op_in,
    input  wire logic        config_mismatch_in,
    input  wire logic        watchdog_clear_instr_in,
    input  wire logic        power_save_instr_in,
    input  wire logic        power_save_idle_in,
    input  wire logic        deep_sleep_arm_in,
    input  wire logic        supply_brownout_in,
    input  wire logic        supply_poweron_in,
    input  wire logic        battery_poweron_in,
    input  wire logic        vbat_present_in,
    input  wire logic        watchdog_fuse_in,
    input  wire logic        clk_switch_en_in,
    input  wire logic [2:0]  fuse_osc_select_in,
    input  wire logic        osc_switch_done_in,
    input  wire logic [2:0]  osc_switch_sel_in,
    input  wire logic        osc_in,
    input  wire logic        osc_needs_ost_in,
    input  wire logic        pll_used_in,
    input  wire logic        pll_lock_in,
    input  wire logic        two_speed_in,
    input  wire logic        frc_ready_in,
    input  wire logic        clock_fail_monitor_enable_in,
    output logic             master_reset_n_out,
    output logic             por_reset_n_out,
    output logic             wdt_enable_out,
    output logic      [2:0]  current_osc_select_out,
    output logic             clk_on_frc_out,
    output logic             sys_clk_valid_out,
    output logic             clock_fail_monitor_out
);

    typedef struct packed {
        logic [15:0] reset_cause_control;
        logic [3:0]  battery_reset_status;
        logic [15:0] rdata;
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic [2:0]  s3;
        logic [2:0]  lvl;
        logic [2:0]  pexit;
        mrst_state_t state;
        logic [1:0]  rtype;
        logic [8:0]  dcnt;
        logic        mrst_n;
        logic        por_n;
        logic [8:0]  fcnt;
        logic        clock_fail_monitor;
        logic [9:0]  ocnt;
        logic        odone;
        logic [2:0]  current_osc_select;
        logic        on_frc;
        logic        clk_ok;
        logic        wdt_en;
    } regs_t;

    localparam regs_t REGS_INIT = '{
        reset_cause_control:   RESET_CAUSE_POR,
        battery_reset_status:  BATTERY_POR,
        rdata:  16'h0000,
        s1:     PIN_INIT,
        s2:     PIN_INIT,
        s3:     PIN_INIT,
        lvl:    PIN_INIT,
        pexit:  PEXIT_INIT,
        state:  ST_HOLD,
        rtype:  RT_POR,
        dcnt:   9'h000,
        mrst_n: 1'b0,
        por_n:  1'b0,
        fcnt:   9'h000,
        clock_fail_monitor:   1'b0,
        ocnt:   10'h000,
        odone:  1'b0,
        current_osc_select:   3'h0,
        on_frc: 1'b0,
        clk_ok: 1'b0,
        wdt_en: 1'b1
    };

    function automatic logic [1:0] rt_max(input logic [1:0] a, input logic [1:0] b);
        rt_max = (a > b) ? a : b;
    endfunction

    function automatic logic [8:0] rt_delay(input logic [1:0] rt);
        case (rt)
            RT_POR:  rt_delay = 9'(POR_CYC + VREG_CYC + RST_CYC);
            RT_BOR:  rt_delay = 9'(VREG_CYC + RST_CYC);
            default: rt_delay = RST_CYC;
        endcase
    endfunction

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    regs_t       q;
    regs_t       d;
    logic        mclr_act;
    logic        bor_rst;
    logic        src;
    logic [1:0]  stype;
    logic        osc_edge;
    logic        vbat_exit;
    logic        prim_ok;
    logic [15:0] set1;
    logic [15:0] clr1;
    logic [15:0] base1;
    logic [3:0]  base2;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        // pin synchronisers, level taken once stages two and three agree
        d.s1 = {osc_in, vbat_present_in, mclr_n_in};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < 3; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s2[i];
            end
        end
        osc_edge = q.s2[PIN_OSC] & q.s3[PIN_OSC] & ~q.lvl[PIN_OSC];

        // reset sources
        mclr_act = ~q.lvl[PIN_MCLR];
        bor_rst  = bor_detect_in & brownout_fuse_in;
        src = por_req_in | bor_rst | mclr_act | wdt_timeout_in | reset_instr_in
            | trap_conflict_in | illegal_op_in | config_mismatch_in;
        stype = por_req_in ? RT_POR : (bor_rst ? RT_BOR : RT_OTHER);

        // reset-control flags
        set1 = 16'h0000;
        clr1 = 16'h0000;
        set1[B_TRAP]        = trap_conflict_in;
        set1[B_ILLEGAL]     = illegal_op_in;
        set1[B_MISMATCH]    = config_mismatch_in;
        set1[B_PIN_RESET]   = mclr_act & ~q.reset_cause_control[B_PIN_RESET];
        set1[B_SOFT_RESET]  = reset_instr_in;
        set1[B_WDT_TIMEOUT] = wdt_timeout_in;
        set1[B_SLEEP]       = power_save_instr_in & ~power_save_idle_in;
        set1[B_DEEP_SLEEP]  = power_save_instr_in & ~power_save_idle_in
                            & deep_sleep_arm_in;
        set1[B_IDLE]        = power_save_instr_in & power_save_idle_in;
        set1[B_BROWNOUT]    = bor_rst | por_req_in;
        set1[B_POWERON]     = por_req_in;
        clr1[B_WDT_TIMEOUT] = watchdog_clear_instr_in | power_save_instr_in;
        if (wr_in && addr_in == ADDR_RESET_CAUSE) begin
            base1 = wdata_in;
        end else begin
            base1 = q.reset_cause_control & ~clr1;
        end
        if (por_req_in) begin
            base1 = RESET_CAUSE_POR;
        end
        d.reset_cause_control = (base1 | set1) & RESET_CAUSE_MASK;

        // battery-domain flags, clear by writing zero
        if (q.pexit != 3'h0) begin
            d.pexit = q.pexit - 3'h1;
        end
        vbat_exit = ((q.pexit == 3'h1)
                  | (q.state == ST_DELAY && q.rtype == RT_POR && q.dcnt <= 9'h001 && !src))
                  & q.lvl[PIN_VBAT];
        if (wr_in && addr_in == ADDR_BATTERY) begin
            base2 = q.battery_reset_status & wdata_in[3:0];
        end else begin
            base2 = q.battery_reset_status;
        end
        d.battery_reset_status = base2 | {supply_brownout_in, supply_poweron_in,
                           battery_poweron_in, vbat_exit};

        // register read, one cycle later, zero otherwise
        d.rdata = 16'h0000;
        if (rd_in) begin
            case (addr_in)
                ADDR_RESET_CAUSE: d.rdata = q.reset_cause_control;
                ADDR_BATTERY:     d.rdata = {12'h000, q.battery_reset_status};
                default:          d.rdata = 16'h0000;
            endcase
        end

        // master reset sequence
        case (q.state)
            ST_RUN: begin
                if (src) begin
                    d.state = ST_HOLD;
                    d.rtype = stype;
                end
            end
            ST_HOLD: begin
                if (src) begin
                    d.rtype = rt_max(q.rtype, stype);
                end else begin
                    d.state = ST_DELAY;
                    d.dcnt  = rt_delay(q.rtype);
                end
            end
            ST_DELAY: begin
                if (src) begin
                    d.state = ST_HOLD;
                    d.rtype = rt_max(q.rtype, stype);
                end else if (q.dcnt <= 9'h001) begin
                    d.state = ST_RUN;
                    if (!clk_switch_en_in || q.rtype != RT_OTHER) begin
                        d.current_osc_select = fuse_osc_select_in;
                    end
                end else begin
                    d.dcnt = q.dcnt - 9'h001;
                end
            end
            default: begin
                d.state = ST_HOLD;
            end
        endcase
        if (q.state == ST_RUN && !src && osc_switch_done_in) begin
            d.current_osc_select = osc_switch_sel_in;
        end
        d.mrst_n = (d.state == ST_RUN);
        d.por_n  = d.mrst_n | (d.rtype != RT_POR);

        // start-up timer, independent of master reset delay
        if (src && stype != RT_OTHER) begin
            d.ocnt  = 10'h000;
            d.odone = ~osc_needs_ost_in;
        end else if (!osc_needs_ost_in) begin
            d.odone = 1'b1;
        end else if (osc_edge && !q.odone) begin
            if (q.ocnt == OST_LAST) begin
                d.odone = 1'b1;
            end else begin
                d.ocnt = q.ocnt + 10'h001;
            end
        end
        prim_ok  = q.odone & (~pll_used_in | pll_lock_in);
        d.on_frc = two_speed_in & ~prim_ok;
        d.clk_ok = prim_ok | (two_speed_in & frc_ready_in);

        // clock-fail monitor delay after release
        if (!d.mrst_n) begin
            d.fcnt = 9'h000;
            d.clock_fail_monitor = 1'b0;
        end else if (q.fcnt != CLOCK_FAIL_MONITOR_CYC) begin
            d.fcnt = q.fcnt + 9'h001;
        end else begin
            d.clock_fail_monitor = clock_fail_monitor_enable_in;
        end

        d.wdt_en = watchdog_fuse_in | d.reset_cause_control[B_SOFT_WDT_EN];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            q <= REGS_INIT;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata_out              = q.rdata;
    assign master_reset_n_out     = q.mrst_n;
    assign por_reset_n_out        = q.por_n;
    assign wdt_enable_out         = q.wdt_en;
    assign current_osc_select_out = q.current_osc_select;
    assign clk_on_frc_out         = q.on_frc;
    assign sys_clk_valid_out      = q.clk_ok;
    assign clock_fail_monitor_out = q.clock_fail_monitor;

endmodule

//--- tb/reset_props.sv
// Purpose: port checks of the reset status and timing block
// Assumes: one clock; design leaves reset two edges after release
// Notes:   bound to the top module
`timescale 1ns/1ps
module reset_props
    import reset_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic        rd_in,
    input  wire logic [15:0] rdata_out,
    input  wire logic        reset_instr_in,
    input  wire logic        bor_detect_in,
    input  wire logic        brownout_fuse_in,
    input  wire logic        watchdog_fuse_in,
    input  wire logic        wdt_enable_out,
    input  wire logic        master_reset_n_out,
    input  wire logic        por_reset_n_out,
    input  wire logic        por_req_in,
    input  wire logic        clock_fail_monitor_out
);
    logic [2:0] rdy_q;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) rdy_q <= 3'h0;
        else rdy_q <= {rdy_q[1:0], 1'b1};
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rdy_q[2]);
    ////////////////////////////////////////////////////////////////////////////////
    property p_src; reset_instr_in |=> !master_reset_n_out; endproperty
    a_src: assert property (p_src) else $error("source without master reset");
    property p_bor; brownout_fuse_in && bor_detect_in |=> !master_reset_n_out; endproperty
    a_bor: assert property (p_bor) else $error("brown-out without reset");
    property p_wdt; watchdog_fuse_in |=> wdt_enable_out; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog not forced on");
    property p_por; !por_reset_n_out |-> !master_reset_n_out; endproperty
    a_por: assert property (p_por) else $error("power-on reset outside master");
    property p_porq; por_req_in |=> !por_reset_n_out; endproperty
    a_porq: assert property (p_porq) else $error("power-on reset missing");
    property p_dly; $rose(master_reset_n_out) |-> !$past(master_reset_n_out, 20); endproperty
    a_dly: assert property (p_dly) else $error("master reset too short");
    property p_clock_fail_monitor; $rose(clock_fail_monitor_out) |-> $past(master_reset_n_out, 19); endproperty
    a_clock_fail_monitor: assert property (p_clock_fail_monitor) else $error("monitor started early");
    property p_bat; rd_in && addr_in == ADDR_BATTERY |=> rdata_out[15:4] == 12'h000; endproperty
    a_bat: assert property (p_bat) else $error("battery upper bits set");
endmodule
bind reset_source_status_and_timing reset_props u_props (.*);

//--- tb/reset_source_status_and_timing_tb.sv
// Purpose: self-checking bench of the reset block
// Assumes: register 0 reset cause, 1 battery status
// Notes:   random writes from a fixed seed
`timescale 1ns/1ps
module reset_source_status_and_timing_tb;
    import reset_pkg::*;
    logic sys_clk_in = 1'b0, arst_n_in = 1'b0, osc_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000, rdata_out, v;
    logic por_req_in = 1'b0, bor_detect_in = 1'b0, brownout_fuse_in = 1'b0, mclr_n_in = 1'b1;
    logic wdt_timeout_in = 1'b0, reset_instr_in = 1'b0, trap_conflict_in = 1'b0;
    logic illegal_op_in = 1'b0, config_mismatch_in = 1'b0, watchdog_clear_instr_in = 1'b0;
    logic power_save_instr_in = 1'b0, power_save_idle_in = 1'b0, deep_sleep_arm_in = 1'b0;
    logic supply_brownout_in = 1'b0, supply_poweron_in = 1'b0, battery_poweron_in = 1'b0;
    logic vbat_present_in = 1'b1, watchdog_fuse_in = 1'b0, clk_switch_en_in = 1'b1;
    logic [2:0] fuse_osc_select_in = 3'h5, osc_switch_sel_in = 3'h0, current_osc_select_out;
    logic osc_switch_done_in = 1'b0, osc_needs_ost_in = 1'b1, pll_used_in = 1'b0;
    logic pll_lock_in = 1'b0, two_speed_in = 1'b0, frc_ready_in = 1'b0, clock_fail_monitor_enable_in = 1'b1;
    logic master_reset_n_out, por_reset_n_out, wdt_enable_out;
    logic clk_on_frc_out, sys_clk_valid_out, clock_fail_monitor_out;
    int   failures = 0, checked = 0, n;
    int   bits [7] = '{15, 14, 9, 6, 4, 7, 1};
    int   bat [3] = '{8, 12, 14};
    localparam int OSC_CYC = 4;
    time  t0;
    reset_source_status_and_timing dut (.*);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] cause_after_write(input logic [15:0] w);
        return w & RESET_CAUSE_MASK;
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 cmp(rdata_out, e);
        @(posedge sys_clk_in);
    endtask
    task automatic wait_rel(input int lo);
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (master_reset_n_out !== 1'b1 && n < 400);
        cmp(16'(n >= lo && n <= lo + 10), 16'h0001);
    endtask
    task automatic ps;
        power_save_instr_in <= 1'b1;
        @(posedge sys_clk_in);
        power_save_instr_in <= 1'b0;
    endtask
    task automatic osw;
        osc_switch_sel_in <= 3'h3;
        osc_switch_done_in <= 1'b1;
        @(posedge sys_clk_in);
        osc_switch_done_in <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever begin
            #50 sys_clk_in = ~sys_clk_in;
        end
    end
    initial begin
        forever begin
            #(OSC_CYC * CLK_PERIOD_NS / 2) osc_in = ~osc_in;
        end
    end
    initial begin
        #2000000 failures++;
        report_and_stop();
    end
    initial begin
        void'($urandom(19785));
        repeat (6) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        wait_rel(220);
        repeat (25) @(posedge sys_clk_in);
        cmp(clock_fail_monitor_out, 1'b1);
        rc(ADDR_RESET_CAUSE, 16'h0003);
        rc(ADDR_BATTERY, 16'h000F);
        two_speed_in <= 1'b1;
        frc_ready_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        cmp(sys_clk_valid_out, 1'b1);
        cmp(clk_on_frc_out, 1'b1);
        $display("test power-up done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(ADDR_RESET_CAUSE, v);
            rc(ADDR_RESET_CAUSE, cause_after_write(v));
            cmp(wdt_enable_out, v[5]);
            cmp(master_reset_n_out, 1'b1);
        end
        watchdog_fuse_in <= 1'b1;
        wr(ADDR_RESET_CAUSE, 16'h0000);
        rc(ADDR_RESET_CAUSE, 16'h0000);
        cmp(wdt_enable_out, 1'b1);
        $display("test software flags done");
        ps();
        rc(ADDR_RESET_CAUSE, 16'h0008);
        deep_sleep_arm_in <= 1'b1;
        ps();
        rc(ADDR_RESET_CAUSE, 16'h0408);
        wr(ADDR_RESET_CAUSE, 16'h0010);
        watchdog_clear_instr_in <= 1'b1;
        @(posedge sys_clk_in);
        watchdog_clear_instr_in <= 1'b0;
        rc(ADDR_RESET_CAUSE, 16'h0000);
        wr(ADDR_RESET_CAUSE, 16'h0010);
        power_save_idle_in <= 1'b1;
        ps();
        rc(ADDR_RESET_CAUSE, 16'h0004);
        wr(ADDR_BATTERY, 16'hFFFF);
        rc(ADDR_BATTERY, 16'h000F);
        wr(ADDR_BATTERY, 16'h0000);
        rc(ADDR_BATTERY, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            {supply_brownout_in, supply_poweron_in, battery_poweron_in} <= 3'h4 >> i;
            @(posedge sys_clk_in);
            {supply_brownout_in, supply_poweron_in, battery_poweron_in} <= 3'h0;
            rc(ADDR_BATTERY, 16'(bat[i]));
        end
        $display("test power save done");
        wr(ADDR_RESET_CAUSE, 16'h0000);
        bor_detect_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        bor_detect_in <= 1'b0;
        cmp(master_reset_n_out, 1'b1);
        brownout_fuse_in <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            clk_switch_en_in <= (i != 2);
            osw();
            case (i)
                0: trap_conflict_in <= 1'b1;
                1: illegal_op_in <= 1'b1;
                2: config_mismatch_in <= 1'b1;
                3: reset_instr_in <= 1'b1;
                4: wdt_timeout_in <= 1'b1;
                5: mclr_n_in <= 1'b0;
                default: bor_detect_in <= 1'b1;
            endcase
            repeat (5) @(posedge sys_clk_in);
            {trap_conflict_in, illegal_op_in, config_mismatch_in} <= 3'h0;
            {reset_instr_in, wdt_timeout_in, bor_detect_in, mclr_n_in} <= 4'h1;
            wait_rel((i == 6) ? 120 : 20);
            rc(ADDR_RESET_CAUSE, 16'h0001 << bits[i]);
            cmp(current_osc_select_out, (i == 6 || i == 2) ? 3'h5 : 3'h3);
            wr(ADDR_RESET_CAUSE, 16'h0000);
        end
        $display("test reset sources done");
        osw();
        wr(ADDR_RESET_CAUSE, 16'hC6DC);
        por_req_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        t0 = $time;
        por_req_in <= 1'b0;
        wait_rel(220);
        rc(ADDR_RESET_CAUSE, 16'h0003);
        cmp(current_osc_select_out, 3'h5);
        repeat (10) @(posedge sys_clk_in);
        rc(ADDR_BATTERY, 16'h000F);
        n = 0;
        while (clk_on_frc_out !== 1'b0 && n < 6000) begin
            @(posedge sys_clk_in);
            n++;
        end
        n = int'(($time - t0) / CLK_PERIOD_NS);
        cmp(16'(n >= 1020 * OSC_CYC && n <= 1028 * OSC_CYC), 16'h0001);
        cmp(sys_clk_valid_out, 1'b1);
        $display("test power-on request done");
        report_and_stop();
    end
endmodule
